// file: design/input_limit_pkg.sv
/*
 constants, reset values and the state record of the charger input stage controller.
 assumes a serial-bus front end elsewhere that turns bus frames into byte reads and writes.
*/
// Behaviour
// - input above overvoltage threshold opens input FET
// - lockout when input over or under valid
// - lockout: system-ok released, interrupt asserted
// - lockout: charging off, battery feeds system
// - negative bus voltage turns external gate off
// - writing 0x33 bit 7 enters low power
// - writing 0x33 bit 1 leaves low power
// - pull-up seen on CC leaves low power
// - detected limit code readable at 0x22
// - force bit at 0x21 selects manual limit
// - above charge thermal limit, cut charge current
// - at max die temperature, draw no input
// - load over limit, battery supplements system
// - adaptive loop holds input voltage, regs 0x2C-0x2E
// - type 101, CC not 3A gives 0x17
// - type 100/001, CC not 3A gives 0x13
// - legacy 1x, type 000/010 with CC not 3A, or type 011 with CC 1.5A, gives 0x0E
// - type 011, CC low gives 0x09
// - legacy 01, type 000/010, CC low gives 0x04
// - legacy 01, SDP allowance picks 0x04/0x09/0x0E
package input_limit_pkg;
	// ============================================================
	// register offsets and bit positions
	localparam logic [7:0] OVR_OFS = 8'h21;
	localparam logic [7:0] DET_OFS = 8'h22;
	localparam logic [7:0] ADAPT_VMIN_OFS = 8'h2c;
	localparam logic [7:0] ADAPT_IVL_OFS = 8'h2d;
	localparam logic [7:0] ADAPT_EN_OFS = 8'h2e;
	localparam logic [7:0] LOWPOW_OFS = 8'h33;
	localparam int FORCE_BIT = 7;
	localparam int LP_ENTRY_BIT = 7;
	localparam int LP_EXIT_BIT = 1;
	localparam int ADAPT_EN_BIT = 0;
	// ============================================================
	// limit codes and detection encodings
	localparam logic [4:0] LIM_3A = 5'h1d;
	localparam logic [4:0] LIM_2A4 = 5'h17;
	localparam logic [4:0] LIM_2A = 5'h13;
	localparam logic [4:0] LIM_1A5 = 5'h0e;
	localparam logic [4:0] LIM_1A = 5'h09;
	localparam logic [4:0] LIM_0A5 = 5'h04;
	localparam logic [4:0] LIM_MAX_RED = 5'h1f;
	localparam logic [1:0] LT_NONE = 2'h0;
	localparam logic [1:0] LT_SDP = 2'h1;
	localparam logic [1:0] LT_CDP = 2'h2;
	localparam logic [1:0] LT_DCP = 2'h3;
	localparam logic [2:0] PT_NONE = 3'h0;
	localparam logic [2:0] PT_2A_B = 3'h1;
	localparam logic [2:0] PT_500M = 3'h2;
	localparam logic [2:0] PT_1A = 3'h3;
	localparam logic [2:0] PT_2A = 3'h4;
	localparam logic [2:0] PT_2A4 = 3'h5;
	localparam logic [2:0] PT_3A = 3'h6;
	localparam logic [1:0] CC_1A5 = 2'h2;
	localparam logic [1:0] CC_3A = 2'h3;
	// ============================================================
	// state record and its reset value
	typedef struct packed {
		logic force_r;
		logic [4:0] manual_r;
		logic [4:0] detect_r;
		logic lowpow_r;
		logic lockout_r;
		logic fet_off_r;
		logic neg_gate_off_r;
		logic die_max_r;
		logic chg_reduce_r;
		logic supplement_r;
		logic [7:0] adapt_vmin_r;
		logic [7:0] adapt_ivl_r;
		logic adapt_en_r;
		logic [7:0] adapt_cnt_r;
		logic [4:0] adapt_red_r;
		logic [4:0] limit_r;
		logic [7:0] rdata_r;
	} state_t;
	localparam logic [4:0] MANUAL_RST = 5'h04;
	localparam logic [4:0] DETECT_RST = 5'h04;
	localparam logic [7:0] ADAPT_VMIN_RST = 8'h00;
	localparam logic [7:0] ADAPT_IVL_RST = 8'h10;
	localparam state_t STATE_RST = '{
		manual_r: MANUAL_RST, detect_r: DETECT_RST, limit_r: DETECT_RST,
		adapt_vmin_r: ADAPT_VMIN_RST, adapt_ivl_r: ADAPT_IVL_RST, default: '0};
endpackage : input_limit_pkg

// file: design/input_limit_select_ctrl.sv
/*
 input stage control: lockout, gate control, low power, thermal and adaptive
 current reduction, and the limit-code decoder with software override.
 assumes: analog comparators deliver clean levels synchronous to clk; a serial
 bus front end presents byte accesses on the reg_* port, one cycle each.
*/
`timescale 1ns/10ps
module input_limit_select_ctrl
	import input_limit_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic input_ov,
	input wire logic input_uv,
	input wire logic neg_volt_det,
	input wire logic dfp_pullup_cc1,
	input wire logic dfp_pullup_cc2,
	input wire logic [1:0] legacy_port_type,
	input wire logic [2:0] proprietary_charger_type,
	input wire logic [1:0] cc_current_status,
	input wire logic [1:0] sdp_allowance,
	input wire logic cdp_allowance,
	input wire logic die_over_chg_limit,
	input wire logic die_at_max_limit,
	input wire logic load_over_limit,
	input wire logic adapt_vin_low,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	output logic input_fet_on,
	output logic input_lockout,
	output logic system_ok_out,
	output logic system_ok_oe,
	output logic int_n_out,
	output logic int_n_oe,
	output logic neg_volt_gate_out,
	output logic charge_enable,
	output logic batt_switch_closed,
	output logic charge_current_reduce,
	output logic input_path_off,
	output logic low_power,
	output logic [7:0] adapt_vin_min,
	output logic [4:0] input_limit_value
);
	// ============================================================
	// limit decoder, rows in table priority
	function automatic logic [5:0] decode_limit(
		input logic [1:0] lt,
		input logic [2:0] pt,
		input logic [1:0] cc,
		input logic [1:0] sdp,
		input logic cdp
	);
		logic [5:0] r;
		logic cc_low;
		r = 6'h00;
		cc_low = (cc < CC_1A5);
		// no legacy detection yet: keep the previous code
		if (lt == LT_NONE)
			r = 6'h00;
		else if ((cc == CC_3A && sdp == 2'h0 && !cdp) || (lt == LT_DCP && cc == CC_3A)
			|| pt == PT_3A)
			r = {1'b1, LIM_3A};
		else if (pt == PT_2A4 && cc != CC_3A)
			r = {1'b1, LIM_2A4};
		else if ((pt == PT_2A || pt == PT_2A_B) && cc != CC_3A)
			r = {1'b1, LIM_2A};
		else if (lt[1] && (pt == PT_NONE || pt == PT_500M) && cc != CC_3A)
			r = {1'b1, LIM_1A5};
		else if (lt[1] && (pt == PT_NONE || pt == PT_500M || pt == PT_1A) && cc == CC_1A5)
			r = {1'b1, LIM_1A5};
		else if (pt == PT_1A && cc_low)
			r = {1'b1, LIM_1A};
		else if (lt == LT_SDP && (pt == PT_NONE || pt == PT_500M) && cc_low)
			r = {1'b1, LIM_0A5};
		else if (lt == LT_SDP && pt == PT_NONE && !cc_low && sdp != 2'h0)
		begin
			if (sdp == 2'h1)
				r = {1'b1, LIM_0A5};
			else if (sdp == 2'h2)
				r = {1'b1, LIM_1A};
			else
				r = {1'b1, LIM_1A5};
		end
		else if (lt == LT_CDP && pt == PT_NONE && cc == CC_3A && cdp)
			r = {1'b1, LIM_1A5};
		return r;
	endfunction : decode_limit

	function automatic logic [4:0] sat_sub(input logic [4:0] a, input logic [4:0] b);
		return (a > b) ? 5'(a - b) : 5'h00;
	endfunction : sat_sub

	// ============================================================
	// state update
	state_t st_r;
	state_t st_nxt;
	logic [5:0] dec;
	logic wr_lp;
	logic lp_exit;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.fet_off_r = input_ov;
		st_nxt.lockout_r = input_ov | input_uv;
		st_nxt.neg_gate_off_r = neg_volt_det;
		st_nxt.die_max_r = die_at_max_limit;
		st_nxt.chg_reduce_r = die_over_chg_limit | die_at_max_limit;
		// battery fills the gap whenever the input cannot carry the load
		st_nxt.supplement_r = load_over_limit | input_ov | input_uv
			| die_at_max_limit;
		dec = decode_limit(legacy_port_type, proprietary_charger_type,
			cc_current_status, sdp_allowance, cdp_allowance);
		if (dec[5])
			st_nxt.detect_r = dec[4:0];
		// register writes
		wr_lp = reg_we && reg_addr == LOWPOW_OFS;
		if (reg_we && reg_addr == OVR_OFS)
		begin
			st_nxt.force_r = reg_wdata[FORCE_BIT];
			st_nxt.manual_r = reg_wdata[4:0];
		end
		else if (reg_we && reg_addr == ADAPT_VMIN_OFS)
			st_nxt.adapt_vmin_r = reg_wdata;
		else if (reg_we && reg_addr == ADAPT_IVL_OFS)
			st_nxt.adapt_ivl_r = reg_wdata;
		else if (reg_we && reg_addr == ADAPT_EN_OFS)
			st_nxt.adapt_en_r = reg_wdata[ADAPT_EN_BIT];
		// exit wins over entry so a plugged adapter is never ignored
		lp_exit = (wr_lp && reg_wdata[LP_EXIT_BIT]) || dfp_pullup_cc1 || dfp_pullup_cc2;
		if (lp_exit)
			st_nxt.lowpow_r = 1'b0;
		else if (wr_lp && reg_wdata[LP_ENTRY_BIT])
			st_nxt.lowpow_r = 1'b1;
		// adaptive loop: one reduction step per interval while input sags
		if (!st_r.adapt_en_r)
		begin
			st_nxt.adapt_cnt_r = 8'h00;
			st_nxt.adapt_red_r = 5'h00;
		end
		else if (st_r.adapt_cnt_r >= st_r.adapt_ivl_r)
		begin
			st_nxt.adapt_cnt_r = 8'h00;
			if (adapt_vin_low && st_r.adapt_red_r != LIM_MAX_RED)
				st_nxt.adapt_red_r = 5'(st_r.adapt_red_r + 5'h01);
			else if (!adapt_vin_low && st_r.adapt_red_r != 5'h00)
				st_nxt.adapt_red_r = 5'(st_r.adapt_red_r - 5'h01);
		end
		else
			st_nxt.adapt_cnt_r = 8'(st_r.adapt_cnt_r + 8'h01);
		st_nxt.limit_r = sat_sub(st_r.force_r ? st_r.manual_r : st_r.detect_r,
			st_r.adapt_red_r);
		// register reads; unmapped addresses read zero
		if (reg_re)
		begin
			if (reg_addr == OVR_OFS)
				st_nxt.rdata_r = {st_r.force_r, 2'h0, st_r.manual_r};
			else if (reg_addr == DET_OFS)
				st_nxt.rdata_r = {3'h0, st_r.detect_r};
			else if (reg_addr == ADAPT_VMIN_OFS)
				st_nxt.rdata_r = st_r.adapt_vmin_r;
			else if (reg_addr == ADAPT_IVL_OFS)
				st_nxt.rdata_r = st_r.adapt_ivl_r;
			else if (reg_addr == ADAPT_EN_OFS)
				st_nxt.rdata_r = {7'h00, st_r.adapt_en_r};
			else if (reg_addr == LOWPOW_OFS)
				st_nxt.rdata_r = {st_r.lowpow_r, 7'h00};
			else
				st_nxt.rdata_r = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_r <= STATE_RST;
		else if (ce)
			st_r <= st_nxt;
	end

	// ============================================================
	// outputs, all straight from state
	assign reg_rdata = st_r.rdata_r;
	assign input_fet_on = !st_r.fet_off_r;
	assign input_lockout = st_r.lockout_r;
	// open-drain: system-ok pulled low when healthy, released in lockout
	assign system_ok_out = 1'b0;
	assign system_ok_oe = !st_r.lockout_r;
	assign int_n_out = 1'b0;
	assign int_n_oe = st_r.lockout_r;
	assign neg_volt_gate_out = st_r.neg_gate_off_r;
	assign charge_enable = !st_r.lockout_r && !st_r.die_max_r && !st_r.lowpow_r;
	assign batt_switch_closed = st_r.supplement_r;
	assign charge_current_reduce = st_r.chg_reduce_r;
	assign input_path_off = st_r.die_max_r || st_r.fet_off_r;
	assign low_power = st_r.lowpow_r;
	assign adapt_vin_min = st_r.adapt_vmin_r;
	assign input_limit_value = st_r.limit_r;

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence lp_entry_wr;
		ce && reg_we && reg_addr == LOWPOW_OFS && reg_wdata[LP_ENTRY_BIT]
			&& !reg_wdata[LP_EXIT_BIT] && !dfp_pullup_cc1 && !dfp_pullup_cc2;
	endsequence
	sequence lp_hold;
		!ce || !(reg_we && reg_addr == LOWPOW_OFS && reg_wdata[LP_EXIT_BIT])
			&& !dfp_pullup_cc1 && !dfp_pullup_cc2;
	endsequence

	fet_off_a: assert property (ce && input_ov |=> !input_fet_on && input_path_off)
		else $error("input fet left on during overvoltage");
	lockout_set_a: assert property (ce && (input_ov || input_uv) |=> input_lockout)
		else $error("lockout not entered");
	lockout_pins_a: assert property (input_lockout |-> !system_ok_oe && int_n_oe)
		else $error("lockout pins wrong");
	lockout_chg_a: assert property (input_lockout |-> !charge_enable && batt_switch_closed)
		else $error("charging not stopped in lockout");
	neg_gate_a: assert property (ce && neg_volt_det |=> neg_volt_gate_out)
		else $error("negative voltage gate not driven");
	lp_entry_a: assert property (lp_entry_wr ##1 lp_hold |=> low_power)
		else $error("low power not held after entry");
	lp_exit_a: assert property (ce && reg_we && reg_addr == LOWPOW_OFS
		&& reg_wdata[LP_EXIT_BIT] |=> !low_power)
		else $error("manual low power exit failed");
	lp_auto_a: assert property (ce && (dfp_pullup_cc1 || dfp_pullup_cc2) |=> !low_power)
		else $error("pull-up did not end low power");
	det_read_a: assert property (ce && reg_re && reg_addr == DET_OFS
		|=> reg_rdata == {3'h0, $past(st_r.detect_r)})
		else $error("detected code read back wrong");
	force_sel_a: assert property (ce && st_r.force_r && st_r.adapt_red_r == 5'h00
		|=> input_limit_value == $past(st_r.manual_r))
		else $error("forced limit not applied");
	thermal_a: assert property (ce && die_over_chg_limit |=> charge_current_reduce)
		else $error("charge current not reduced");
	max_temp_a: assert property (ce && die_at_max_limit
		|=> input_path_off && batt_switch_closed)
		else $error("input still drawn at max temperature");
	supplement_a: assert property (ce && load_over_limit |=> batt_switch_closed)
		else $error("battery not supplementing");
	code_2a4_a: assert property (ce && legacy_port_type != LT_NONE
		&& proprietary_charger_type == PT_2A4 && cc_current_status != CC_3A
		|=> st_r.detect_r == LIM_2A4)
		else $error("2.4A code wrong");
	code_2a_a: assert property (ce && legacy_port_type != LT_NONE
		&& (proprietary_charger_type == PT_2A || proprietary_charger_type == PT_2A_B)
		&& cc_current_status != CC_3A |=> st_r.detect_r == LIM_2A)
		else $error("2A code wrong");
	code_1a_a: assert property (ce && legacy_port_type != LT_NONE
		&& proprietary_charger_type == PT_1A && cc_current_status < CC_1A5
		|=> st_r.detect_r == LIM_1A)
		else $error("1A code wrong");
	code_3a_a: assert property (ce && legacy_port_type != LT_NONE
		&& proprietary_charger_type == PT_3A |=> st_r.detect_r == LIM_3A)
		else $error("3A code wrong");
	code_keep_a: assert property (ce && legacy_port_type == LT_NONE
		|=> $stable(st_r.detect_r))
		else $error("code changed without detection");
	code_1a5_a: assert property (ce && legacy_port_type[1]
		&& (proprietary_charger_type == PT_NONE || proprietary_charger_type == PT_500M)
		&& cc_current_status != CC_3A |=> st_r.detect_r == LIM_1A5)
		else $error("1.5A legacy code wrong");
	code_0a5_a: assert property (ce && legacy_port_type == LT_SDP
		&& (proprietary_charger_type == PT_NONE || proprietary_charger_type == PT_500M)
		&& cc_current_status < CC_1A5 |=> st_r.detect_r == LIM_0A5)
		else $error("0.5A code wrong");
	sdp_pick_a: assert property (ce && legacy_port_type == LT_SDP
		&& proprietary_charger_type == PT_NONE && cc_current_status == CC_1A5
		&& sdp_allowance == 2'h2 |=> st_r.detect_r == LIM_1A)
		else $error("sdp allowance code wrong");
	cdp_code_a: assert property (ce && legacy_port_type == LT_CDP
		&& proprietary_charger_type == PT_NONE && cc_current_status == CC_3A
		&& cdp_allowance |=> st_r.detect_r == LIM_1A5)
		else $error("cdp allowance code wrong");
	lp_charge_a: assert property (low_power |-> !charge_enable)
		else $error("charging left on in low power");
	ovp_path_a: assert property (!input_fet_on |-> input_path_off)
		else $error("input path open with fet off");
	// a frozen block must not drift, or a stalled bus would corrupt settings
	ce_freeze_a: assert property (!ce |=> $stable(st_r))
		else $error("state changed while clock enable low");
	rdata_hold_a: assert property (!(ce && reg_re) |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule : input_limit_select_ctrl

// file: test/adapter_model.sv
/*
 charging adapter on the charger input: voltage condition flags and cc pull-ups.
 assumes the bench commands a condition code and changes it at the falling edge.
*/
`timescale 1ns/10ps
module adapter_model
(
	input wire logic clk,
	input wire logic [1:0] cond,
	input wire logic slow,
	input wire logic [1:0] attach,
	output logic ov,
	output logic uv,
	output logic neg,
	output logic pu1,
	output logic pu2
);
	// ============================================================
	// condition decode
	logic [1:0] c_r;
	logic [1:0] c;
	initial c_r = 2'h0;
	// a slow adapter lets its level settle one cycle late
	always_ff @(posedge clk)
		c_r <= cond;
	assign c = slow ? c_r : cond;
	assign ov = c == 2'h1;
	assign uv = c == 2'h2;
	assign neg = c == 2'h3;
	assign pu1 = attach[0];
	assign pu2 = attach[1];
endmodule : adapter_model

// file: test/tb_input_limit_select_ctrl.sv
/*
 self-checking bench of the input stage controller: registers, lockout, low power, decoder.
 assumes the controller package and the adapter model on the input side.
*/
`timescale 1ns/10ps
module tb_input_limit_select_ctrl;
	import input_limit_pkg::*;
	// ============================================================
	// wiring
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, slow = 1'b0, cdp = 1'b0;
	logic [1:0] cond = 2'h0, attach = 2'h0, lt = 2'h0, cc = 2'h0, sdp = 2'h0;
	logic [2:0] pt = 3'h0;
	logic dhot = 1'b0, dmax = 1'b0, lovr = 1'b0, vlow = 1'b0, we = 1'b0, re = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, vmin, rv;
	logic ov, uv, neg, pu1, pu2, fet, lock, sok, sok_oe, intn, intn_oe;
	logic gate, chg, bsw, red, poff, lp;
	logic [4:0] lim, code;
	logic [31:0] rnd = 32'ha5bf;
	int fail_count = 0, n_tests = 0, cyc = 0;
	always #10 clk = ~clk;
	adapter_model i_adp (.clk(clk), .cond(cond), .slow(slow), .attach(attach), .ov(ov),
		.uv(uv), .neg(neg), .pu1(pu1), .pu2(pu2));
	input_limit_select_ctrl i_dut (.clk(clk), .srst(srst), .ce(ce), .input_ov(ov),
		.input_uv(uv), .neg_volt_det(neg), .dfp_pullup_cc1(pu1), .dfp_pullup_cc2(pu2),
		.legacy_port_type(lt), .proprietary_charger_type(pt), .cc_current_status(cc),
		.sdp_allowance(sdp), .cdp_allowance(cdp), .die_over_chg_limit(dhot),
		.die_at_max_limit(dmax), .load_over_limit(lovr), .adapt_vin_low(vlow),
		.reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
		.input_fet_on(fet), .input_lockout(lock), .system_ok_out(sok),
		.system_ok_oe(sok_oe), .int_n_out(intn), .int_n_oe(intn_oe),
		.neg_volt_gate_out(gate), .charge_enable(chg), .batt_switch_closed(bsw),
		.charge_current_reduce(red), .input_path_off(poff), .low_power(lp),
		.adapt_vin_min(vmin), .input_limit_value(lim));
	// ============================================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	// table rows in priority order; no match keeps the old code
	function automatic logic [4:0] ref_code(input logic [4:0] old);
		if (lt == 2'h0) return old;
		if (cc == 2'h3 && sdp == 2'h0 && !cdp) return 5'h1d;
		if (lt == 2'h3 && cc == 2'h3) return 5'h1d;
		if (pt == 3'h6) return 5'h1d;
		if (pt == 3'h5 && cc != 2'h3) return 5'h17;
		if ((pt == 3'h4 || pt == 3'h1) && cc != 2'h3) return 5'h13;
		if (lt[1] && (pt == 3'h0 || pt == 3'h2) && cc != 2'h3) return 5'h0e;
		if (lt[1] && pt <= 3'h3 && pt != 3'h1 && cc == 2'h2) return 5'h0e;
		if (pt == 3'h3 && !cc[1]) return 5'h09;
		if (lt == 2'h1 && (pt == 3'h0 || pt == 3'h2) && !cc[1]) return 5'h04;
		if (lt == 2'h1 && pt == 3'h0 && sdp != 2'h0) return sdp == 2'h1 ? 5'h04 :
			sdp == 2'h2 ? 5'h09 : 5'h0e;
		if (lt == 2'h2 && pt == 3'h0 && cc == 2'h3 && cdp) return 5'h0e;
		return old;
	endfunction : ref_code
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		d = rdata;
	endtask : rd
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	// ============================================================
	// timeout: whole sequence needs about 460 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			end_sim();
		end
	end
	// ============================================================
	// sequence
	initial
	begin
		code = DETECT_RST;
		step(12);
		srst = 1'b0;
		step(1);
		chk("idle", {fet, lock, sok_oe, intn_oe, gate, chg, bsw, red}, 8'ha4);
		chk("lim0", 8'(lim), 8'h04);
		rd(8'h40, rv);
		chk("unmapped", rv, 8'h00);
		for (int i = 0; i < 60; i++)
		begin
			rnd = nxt(rnd);
			{lt, pt, cc, sdp, cdp} = rnd[9:0];
			if (i < 8)
				pt = 3'(i);
			code = ref_code(code);
			step(3);
			chk("lim", 8'(lim), 8'(code));
			rd(DET_OFS, rv);
			chk("det", rv, {3'h0, code});
		end
		wr(DET_OFS, 8'h1f);
		rd(DET_OFS, rv);
		chk("det_ro", rv, {3'h0, code});
		wr(OVR_OFS, 8'h8a);
		step(2);
		chk("forced", 8'(lim), 8'h0a);
		wr(ADAPT_VMIN_OFS, 8'h5c);
		chk("vmin", vmin, 8'h5c);
		wr(ADAPT_IVL_OFS, 8'h00);
		wr(ADAPT_EN_OFS, 8'h01);
		vlow = 1'b1;
		step(40);
		chk("adapt_low", 8'(lim), 8'h00);
		vlow = 1'b0;
		step(40);
		chk("adapt_back", 8'(lim), 8'h0a);
		wr(ADAPT_EN_OFS, 8'h00);
		wr(OVR_OFS, 8'h00);
		step(3);
		chk("unforced", 8'(lim), 8'(code));
		// a write while frozen must be dropped
		ce = 1'b0;
		wr(OVR_OFS, 8'h85);
		ce = 1'b1;
		rd(OVR_OFS, rv);
		chk("ce_hold", rv, 8'h00);
		for (int k = 1; k < 3; k++)
		begin
			slow = k[0];
			cond = 2'(k);
			step(3);
			chk("lockout", {3'h0, lock, sok_oe, intn_oe, chg, bsw}, 8'h15);
			if (k == 1)
				chk("fet", 8'(fet), 8'h00);
			cond = 2'h0;
			step(3);
			chk("release", {6'h0, fet, lock}, 8'h02);
		end
		cond = 2'h3;
		step(3);
		chk("gate", 8'(gate), 8'h01);
		cond = 2'h0;
		wr(LOWPOW_OFS, 8'h80);
		step(1);
		chk("lp_on", 8'(lp), 8'h01);
		wr(LOWPOW_OFS, 8'h02);
		step(1);
		chk("lp_exit", 8'(lp), 8'h00);
		for (int p = 1; p < 3; p++)
		begin
			wr(LOWPOW_OFS, 8'h80);
			attach = 2'(p);
			step(2);
			chk("lp_cc", 8'(lp), 8'h00);
			attach = 2'h0;
		end
		dhot = 1'b1;
		step(2);
		chk("reduce", 8'(red), 8'h01);
		dmax = 1'b1;
		step(2);
		chk("maxtemp", {6'h0, poff, chg}, 8'h02);
		dhot = 1'b0;
		dmax = 1'b0;
		lovr = 1'b1;
		step(2);
		chk("supplement", 8'(bsw), 8'h01);
		lovr = 1'b0;
		step(2);
		end_sim();
	end
endmodule : tb_input_limit_select_ctrl
